// >>> core/spu_core.sv
// Security password and unlock command interpreter with an AHB-Lite register slave.
`timescale 1ns/10ps
`include "spu_regs.svh"

// Notes on behaviour
// - Set-password opcodes BAh/F1h, one data sector.
// - Abort set-password if unsupported, locked, frozen.
// - User high: store, lock next boot, both unlock.
// - User maximum: store, only user password unlocks.
// - Master identifier: store master, no lock enable.
// - Unlock opcodes BBh/F2h, same sector layout.
// - Abort unlock if unsupported or frozen.
// - Master unlock at high compares master password.
// - Master unlock at maximum is rejected.
// - User unlock compares user password.
// - Mismatch aborts and decrements attempt counter.
// - Counter starts five, decrements on locked mismatch.
// - Counter zero aborts unlock until reset.
// - Unlock while unlocked leaves counter unchanged.
// - Freeze lock rejects set-password and unlock until power off.
module spu_core
    import spu_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt and lock state.
    output logic irq,
    output logic locked
);

    // ------------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------------
    logic rst_meta; // First stage, read only by the second.
    logic rst_sync_n; // Released reset used everywhere else.

    // Assert at once, release after two edges.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------------
    logic dp_valid; // A transfer is in its data phase.
    logic dp_write; // The data phase is a write.
    logic [11:0] dp_addr; // Word address of the data phase.
    logic wr_cmd, wr_data, wr_ctrl, wr_istat, wr_imask; // Decoded register write strobes.

    // Every transfer is answered with zero wait states; hready is always high here.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
        end else if (hready) begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_addr <= {haddr[11:2], 2'b00};
        end
    end

    assign wr_cmd = dp_valid && dp_write && (dp_addr == `SPU_OFF_CMD);
    assign wr_data = dp_valid && dp_write && (dp_addr == `SPU_OFF_DATA);
    assign wr_ctrl = dp_valid && dp_write && (dp_addr == `SPU_OFF_CTRL);
    assign wr_istat = dp_valid && dp_write && (dp_addr == `SPU_OFF_IRQ_STAT);
    assign wr_imask = dp_valid && dp_write && (dp_addr == `SPU_OFF_IRQ_MASK);
    // Reads need no strobe here: read data is registered from the address phase.

    // Slave is always ready and always answers OKAY.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Security state
    // ------------------------------------------------------------------------
    spu_state_t state; // Command sequencer state.
    spu_cmd_t cmd; // Command being run.
    logic [8:0] word_idx; // Sector word being received.
    logic [15:0] ctrl_word; // Captured control word of the sector.
    logic [15:0] pw_in [1:16]; // Password received with the sector.
    logic [15:0] pw_user [1:16]; // Stored user password.
    logic [15:0] pw_master [1:16]; // Stored master password.
    logic level_max; // Stored security level, 1 for maximum.
    logic lock_enable; // Lock takes effect from next power-on.
    logic frozen; // Frozen mode, left only by reset.
    logic [2:0] tries; // Remaining unlock attempts.
    logic supported; // Software enable for the feature set.
    logic st_err, st_abrt, st_drq, st_bsy; // Task-file status bits.
    logic [1:0] irq_stat, irq_mask;
    logic match_user, match_master;
    logic ev_done, ev_abort; // One-cycle completion events.

    // Password comparators over the sixteen words.
    always_comb begin
        match_user = 1'b1;
        match_master = 1'b1;
        for (int i = 1; i <= 16; i++) begin
            if (pw_in[i] != pw_user[i]) match_user = 1'b0;
            if (pw_in[i] != pw_master[i]) match_master = 1'b0;
        end
    end

    // Software enable of the feature; lock_at_boot is acted on by the sequencer on a control write while idle once lock_enable is set.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            supported <= 1'b1;
        end else if (wr_ctrl) begin
            supported <= hwdata[`SPU_CTRL_SUPPORTED];
        end
    end

    // Password store; it stands in for non-volatile memory and is not reset-cleared.
    always_ff @(posedge clk) begin
        if (state == SPU_XFER && wr_data && word_idx >= `SPU_PW_FIRST
                && word_idx <= `SPU_PW_LAST) begin
            pw_in[word_idx[4:0]] <= hwdata[15:0];
        end
        if (state == SPU_EXEC && cmd == SPU_CMD_SETPW) begin
            for (int i = 1; i <= 16; i++) begin
                if (ctrl_word[`SPU_CW_ID_BIT]) begin
                    pw_master[i] <= pw_in[i];
                end else begin
                    pw_user[i] <= pw_in[i];
                end
            end
        end
    end

    // Command sequencer, lock, freeze and attempt counter.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= SPU_IDLE;
            cmd <= SPU_CMD_NONE;
            word_idx <= 9'h000;
            ctrl_word <= 16'h0000;
            level_max <= 1'b0;
            lock_enable <= 1'b0;
            locked <= 1'b0;
            frozen <= 1'b0;
            tries <= `SPU_TRIES_INIT;
            st_err <= 1'b0;
            st_abrt <= 1'b0;
            st_drq <= 1'b0;
            st_bsy <= 1'b0;
            ev_done <= 1'b0;
            ev_abort <= 1'b0;
        end else begin
            ev_done <= 1'b0;
            ev_abort <= 1'b0;
            unique case (state)
                SPU_IDLE: begin
                    if (wr_cmd) begin
                        st_err <= 1'b0;
                        st_abrt <= 1'b0;
                        word_idx <= 9'h000;
                        if (hwdata[7:0] == `SPU_OP_SETPW_A || hwdata[7:0] == `SPU_OP_SETPW_B) begin
                            if (!supported || locked || frozen) begin
                                st_err <= 1'b1;
                                st_abrt <= 1'b1;
                                ev_abort <= 1'b1;
                            end else begin
                                cmd <= SPU_CMD_SETPW;
                                st_drq <= 1'b1;
                                state <= SPU_XFER;
                            end
                        end else if (hwdata[7:0] == `SPU_OP_UNLOCK_A
                                || hwdata[7:0] == `SPU_OP_UNLOCK_B) begin
                            if (!supported || frozen || tries == 3'h0) begin
                                st_err <= 1'b1;
                                st_abrt <= 1'b1;
                                ev_abort <= 1'b1;
                            end else begin
                                cmd <= SPU_CMD_UNLOCK;
                                st_drq <= 1'b1;
                                state <= SPU_XFER;
                            end
                        end else if (hwdata[7:0] == `SPU_OP_FREEZE_A
                                || hwdata[7:0] == `SPU_OP_FREEZE_B) begin
                            if (!supported || locked) begin
                                st_err <= 1'b1;
                                st_abrt <= 1'b1;
                                ev_abort <= 1'b1;
                            end else begin
                                frozen <= 1'b1;
                                ev_done <= 1'b1;
                            end
                        end else begin
                            // Other opcodes belong to other blocks and are aborted here.
                            st_err <= 1'b1;
                            st_abrt <= 1'b1;
                            ev_abort <= 1'b1;
                        end
                    end
                end
                SPU_XFER: begin
                    // Exactly one sector of 256 words is taken, one word per write.
                    if (wr_data) begin
                        if (word_idx == 9'h000) ctrl_word <= hwdata[15:0];
                        word_idx <= word_idx + 9'h001;
                        if (word_idx == `SPU_SECTOR_WORDS - 9'h001) begin
                            st_drq <= 1'b0;
                            st_bsy <= 1'b1;
                            state <= SPU_EXEC;
                        end
                    end
                end
                SPU_EXEC: begin
                    st_bsy <= 1'b0;
                    state <= SPU_IDLE;
                    if (cmd == SPU_CMD_SETPW) begin
                        if (!ctrl_word[`SPU_CW_ID_BIT]) begin
                            level_max <= ctrl_word[`SPU_CW_LEVEL_BIT];
                            lock_enable <= 1'b1;
                        end
                        ev_done <= 1'b1;
                    end else if (!locked) begin
                        ev_done <= 1'b1;
                    end else if (ctrl_word[`SPU_CW_ID_BIT] ? (!level_max && match_master)
                            : match_user) begin
                        locked <= 1'b0;
                        ev_done <= 1'b1;
                    end else begin
                        tries <= tries - 3'h1;
                        st_err <= 1'b1;
                        st_abrt <= 1'b1;
                        ev_abort <= 1'b1;
                    end
                    cmd <= SPU_CMD_NONE;
                end
            endcase
            // A write of lock_at_boot stands in for the power-on that arms the lock.
            if (wr_ctrl && hwdata[`SPU_CTRL_LOCK_AT_BOOT] && lock_enable && state == SPU_IDLE) begin
                locked <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts: sticky status, write one to clear, set wins
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_istat ? hwdata[1:0] : 2'b00))
                | {ev_abort, ev_done};
            if (wr_imask) irq_mask <= hwdata[1:0];
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------------------
    // Read data: loaded for the data phase of a read, held otherwise
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case ({haddr[11:2], 2'b00})
                `SPU_OFF_STATUS: hrdata <= {16'h0000, 5'h00, st_abrt, 2'b00,
                    st_bsy, 1'b1, 2'b00, st_drq, 2'b00, st_err};
                // The counter sits in the low bits so software reads it without a shift.
                `SPU_OFF_CTRL: hrdata <= {24'h00_0000, frozen, locked, level_max,
                    lock_enable, 1'b0, tries};
                `SPU_OFF_IRQ_STAT: hrdata <= {30'h0, irq_stat};
                `SPU_OFF_IRQ_MASK: hrdata <= {30'h0, irq_mask};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // spu_core

// >>> core/spu_pkg.sv
// Types shared by the security unlock block.
package spu_pkg;
    // Command handling states.
    typedef enum logic [1:0] {SPU_IDLE, SPU_XFER, SPU_EXEC} spu_state_t;
    // Which security command is in progress.
    typedef enum logic [1:0] {SPU_CMD_NONE, SPU_CMD_SETPW, SPU_CMD_UNLOCK} spu_cmd_t;
endpackage

// >>> core/spu_regs.svh
// Register offsets, field positions, reset values and command codes of the security unlock block.
`ifndef SPU_REGS_SVH
`define SPU_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the AHB-Lite slave
// ----------------------------------------------------------------------------
`define SPU_OFF_CMD 12'h000
`define SPU_OFF_DATA 12'h004
`define SPU_OFF_STATUS 12'h008
`define SPU_OFF_CTRL 12'h00c
`define SPU_OFF_IRQ_STAT 12'h010
`define SPU_OFF_IRQ_MASK 12'h014

// ----------------------------------------------------------------------------
// Command opcodes, two aliases each
// ----------------------------------------------------------------------------
`define SPU_OP_SETPW_A 8'hba
`define SPU_OP_SETPW_B 8'hf1
`define SPU_OP_UNLOCK_A 8'hbb
`define SPU_OP_UNLOCK_B 8'hf2
`define SPU_OP_FREEZE_A 8'hbe
`define SPU_OP_FREEZE_B 8'hf5

// ----------------------------------------------------------------------------
// Sector layout and counter values
// ----------------------------------------------------------------------------
`define SPU_SECTOR_WORDS 9'h100
`define SPU_PW_FIRST 9'h001
`define SPU_PW_LAST 9'h010
`define SPU_CW_ID_BIT 0
`define SPU_CW_LEVEL_BIT 8
`define SPU_TRIES_INIT 3'h5

// ----------------------------------------------------------------------------
// Status register bits and control register bits
// ----------------------------------------------------------------------------
`define SPU_ST_ERR 0
`define SPU_ST_DRQ 3
`define SPU_ST_DRDY 6
`define SPU_ST_BSY 7
`define SPU_ER_ABRT 10
`define SPU_CTRL_SUPPORTED 0
`define SPU_CTRL_LOCK_AT_BOOT 1

// Interrupt status bits: command done and command aborted.
`define SPU_IRQ_DONE 0
`define SPU_IRQ_ABORT 1

`endif

// >>> tb/security_password_unlock_bench.sv
// Self-checking bench for the security password and unlock block.
`timescale 1ns/10ps
`include "spu_regs.svh"
module security_password_unlock_bench import spu_pkg::*;;
    // ----------------------------------------
    // Signals, design and host
    // ----------------------------------------
    logic clk = 1'b0; // 200 MHz clock.
    logic rst_n = 1'b0; // Reset, active low.
    logic hsel, hwrite, hready, hresp, irq, locked, stuck;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int n_mismatch = 0;
    int compares = 0;
    // One row: control write, opcode, control word, password seed, abort, locked, tries.
    typedef struct packed {
        logic [1:0] ctl;
        logic [7:0] op;
        logic [15:0] cw;
        logic [15:0] pw;
        logic abort;
        logic lock;
        logic [3:0] tries;
    } spu_row_t;
    // Rows run in order; the device state carries from one to the next.
    // A freeze while locked and a foreign opcode must both abort.
    spu_row_t rows [17] = '{
        {2'h1, 8'hba, 16'h0001, 16'h1111, 2'b00, 4'h5},
        {2'h1, 8'hf1, 16'h0000, 16'h2222, 2'b00, 4'h5},
        {2'h1, 8'hbb, 16'h0000, 16'h3333, 2'b00, 4'h5},
        {2'h3, 8'hba, 16'h0000, 16'h2222, 2'b11, 4'h5},
        {2'h1, 8'hf2, 16'h0000, 16'h3333, 2'b11, 4'h4},
        {2'h1, 8'hbe, 16'h0000, 16'h0000, 2'b11, 4'h4},
        {2'h1, 8'hbb, 16'h0001, 16'h1111, 2'b00, 4'h4},
        {2'h1, 8'hba, 16'h0100, 16'h2222, 2'b00, 4'h4},
        {2'h3, 8'hbb, 16'h0001, 16'h1111, 2'b11, 4'h8},
        {2'h1, 8'hf2, 16'h0000, 16'h2222, 2'b00, 4'h8},
        {2'h1, 8'h70, 16'h0000, 16'h0000, 2'b10, 4'h8},
        {2'h0, 8'hba, 16'h0000, 16'h2222, 2'b10, 4'h8},
        {2'h0, 8'hbb, 16'h0000, 16'h2222, 2'b10, 4'h8},
        {2'h1, 8'hbe, 16'h0000, 16'h0000, 2'b00, 4'h8},
        {2'h1, 8'hf5, 16'h0000, 16'h0000, 2'b00, 4'h8},
        {2'h1, 8'hba, 16'h0000, 16'h2222, 2'b10, 4'h8},
        {2'h1, 8'hbb, 16'h0000, 16'h2222, 2'b10, 4'h8}};
    always #2.5 clk = ~clk;
    spu_core i_dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
        .hrdata, .hreadyout(hready), .hresp, .irq, .locked);
    spu_host i_host (.clk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .stuck);
    // Counts every compare and reports a difference at once.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // A hung bus or a run that never ends goes straight to the verdict.
    always @(posedge stuck) begin
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end
    // Reset for six cycles, then only aborts reach the interrupt line.
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        i_host.xfer(1'b1, `SPU_OFF_IRQ_MASK, 32'h2, rd);
    endtask
    // Runs one command and checks status, counter, lock and interrupt.
    task automatic run(input spu_row_t r);
        int n;
        i_host.xfer(1'b1, `SPU_OFF_CTRL, {30'h0, r.ctl}, rd);
        i_host.send(r.op, r.cw, r.pw);
        repeat (4) @(posedge clk);
        for (n = 0; n < 20; n++) begin
            i_host.xfer(1'b0, `SPU_OFF_STATUS, 32'h0, rd);
            if (rd[`SPU_ST_BSY] === 1'b0 && rd[`SPU_ST_DRQ] === 1'b0) break;
        end
        if (n == 20) begin
            n_mismatch++;
            tally_and_finish();
        end
        check("status", rd & 32'h4c9, r.abort ? 32'h441 : 32'h40);
        i_host.xfer(1'b0, `SPU_OFF_CTRL, 32'h0, rd);
        if (!r.tries[3]) check("tries", {29'h0, rd[2:0]}, {29'h0, r.tries[2:0]});
        check("locked", {30'h0, locked, rd[6]}, {30'h0, r.lock, r.lock});
        i_host.xfer(1'b0, `SPU_OFF_IRQ_STAT, 32'h0, rd);
        check("irq", {29'h0, irq, rd[1:0]}, {29'h0, r.abort, r.abort, !r.abort});
        i_host.xfer(1'b1, `SPU_OFF_IRQ_STAT, 32'h3, rd);
        repeat (2) @(posedge clk);
        check("irq clear", {31'h0, irq}, 32'h0);
    endtask
    initial begin
        do_reset();
        foreach (rows[i]) begin
            run(rows[i]);
            $display("row %0d done", i);
        end
        // A second reset clears lock and freeze; misses then drain the counter.
        do_reset();
        check("reset lock", {31'h0, locked}, 32'h0);
        run({2'h1, 8'hf1, 16'h0000, 16'h4444, 2'b00, 4'h5});
        for (int k = 4; k >= 0; k--)
            run({(k == 4) ? 2'h3 : 2'h1, 8'hbb, 16'h0, 16'h5555, 2'b11, 4'(k)});
        run({2'h1, 8'hf2, 16'h0000, 16'h4444, 2'b11, 4'h0});
        $display("counter test done");
        // A hard reset refills the counter; the lock is armed again first, because reset
        // also clears the lock enable, so the unlock below meets a locked device.
        do_reset();
        run({2'h1, 8'hba, 16'h0000, 16'h4444, 2'b00, 4'h5});
        i_host.xfer(1'b1, `SPU_OFF_CTRL, 32'h3, rd);
        @(posedge clk);
        check("relock", {31'h0, locked}, 32'h1);
        run({2'h1, 8'hbb, 16'h0000, 16'h4444, 2'b00, 4'h5});
        i_host.xfer(1'b1, 12'h018, 32'hffff_ffff, rd);
        i_host.xfer(1'b0, 12'h018, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        $display("restore test done");
        tally_and_finish();
    end
endmodule // security_password_unlock_bench

// >>> tb/spu_core_sva.sv
// Port-level assertions for the security unlock block, bound to its top module.
`timescale 1ns/10ps
`include "spu_regs.svh"
module spu_core_sva (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Bus request and answer.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Interrupt and lock state.
    input wire logic irq,
    input wire logic locked
);
    // ----------------------------------------
    // Bus phase tracking
    // ----------------------------------------
    logic rd_dp; // A read is in its data phase.
    logic wr_dp; // A write is in its data phase.
    logic [11:0] dp_a; // Offset of the transfer in its data phase.
    logic [5:0] wr_hist; // Recent write data phases; every event follows one.
    logic [2:0] lk_hist; // Recent lock pulse writes.
    wire ap = hsel && htrans[1] && hready;
    // Remember the accepted address phase for its data phase.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_dp <= 1'b0;
            wr_dp <= 1'b0;
            dp_a <= 12'h0;
        end else if (hready) begin
            rd_dp <= ap && !hwrite;
            wr_dp <= ap && hwrite;
            dp_a <= haddr[11:0];
        end
    end
    // Short histories, since an effect may lag its write by a few cycles.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_hist <= 6'h0;
            lk_hist <= 3'h0;
        end else begin
            wr_hist <= {wr_hist[4:0], wr_dp};
            lk_hist <= {lk_hist[1:0], wr_dp && dp_a == `SPU_OFF_CTRL && hwdata[1]};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_recent_wr;
        wr_dp || (|wr_hist);
    endsequence
    bus_answer_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    lock_engage_a: assert property ($rose(locked) |-> (|lk_hist))
        else $error("lock engaged without a lock pulse");
    lock_release_a: assert property ($fell(locked) |-> s_recent_wr)
        else $error("lock released without a command");
    irq_raise_a: assert property ($rose(irq) |-> s_recent_wr)
        else $error("interrupt raised without a cause");
    irq_drop_a: assert property ($fell(irq) |-> s_recent_wr)
        else $error("interrupt dropped without a write");
    unmapped_zero_a: assert property (rd_dp && dp_a > `SPU_OFF_IRQ_MASK |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    drdy_valid_a: assert property (rd_dp && dp_a == `SPU_OFF_STATUS |-> hrdata[6])
        else $error("ready bit low");
    err_pair_a: assert property (
        rd_dp && dp_a == `SPU_OFF_STATUS |-> hrdata[0] == hrdata[10])
        else $error("error and abort bits disagree");
    tries_range_a: assert property (
        rd_dp && dp_a == `SPU_OFF_CTRL |-> hrdata[2:0] <= 3'h5)
        else $error("attempt counter above five");
    rdata_hold_a: assert property (!(ap && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
endmodule // spu_core_sva
bind spu_core spu_core_sva i_sva (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .irq, .locked);

// >>> tb/spu_host.sv
// Host-side bus model that issues security commands to the block.
`timescale 1ns/10ps
`include "spu_regs.svh"
module spu_host (
    // Clock and bus answer.
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Bus request.
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Raised when the block never answers.
    output logic stuck
);
    // ----------------------------------------
    // Bus transfers
    // ----------------------------------------
    // The bus idles from time zero.
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata, stuck} = '0;
    end
    // One single word; each phase holds until hready is seen high at an edge.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge clk);
        for (n = 0; hready !== 1'b1 && n < 50; n++) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        for (n = n; hready !== 1'b1 && n < 50; n++) @(posedge clk);
        rd = hrdata;
        if (n >= 50) stuck <= 1'b1;
    endtask
    // Command write, then one whole sector unless the command is a freeze.
    task automatic send(input logic [7:0] op, input logic [15:0] cw, input logic [15:0] pw);
        logic [31:0] d;
        xfer(1'b1, `SPU_OFF_CMD, {24'h0, op}, d);
        if (op == `SPU_OP_FREEZE_A || op == `SPU_OP_FREEZE_B) return;
        for (int i = 0; i < `SPU_SECTOR_WORDS; i++)
            xfer(1'b1, `SPU_OFF_DATA, (i == 0) ? {16'h0, cw} :
                 (i <= `SPU_PW_LAST) ? {16'h0, pw ^ 16'(i)} : 32'h0, d);
    endtask
endmodule // spu_host
